// [hw/mdr_pkg.sv]
package mdr_pkg;

   localparam int DATA_W = 32;
   localparam int ADDR_W = 16;
   localparam int IDX_W = 12;
   localparam int IDX_LSB = 2;
   localparam int BYTE_W = 8;
   localparam int HALF_W = 16;
   localparam int WORD_W = 32;
   localparam int NUM_REGS = 28;

   // Register indices; the byte address is four times the index
   localparam logic [IDX_W-1:0] REG_IDX [NUM_REGS] = '{
      12'h0f38, 12'h0f39, 12'h0f3a, 12'h0f3b,
      12'h0f3c, 12'h0f3d, 12'h0f3e, 12'h0f3f,
      12'h0f44, 12'h0f45, 12'h0f46, 12'h0f47,
      12'h0f80, 12'h0f81, 12'h0f82, 12'h0f83,
      12'h0f8c, 12'h0f8d, 12'h0f8e, 12'h0f8f,
      12'h0f90, 12'h0f91,
      12'h0f92, 12'h0f93, 12'h0f94, 12'h0f95,
      12'h0f96, 12'h0f97
   };
   localparam logic [IDX_W-1:0] IDX_CTRL = 12'h0f00;
   localparam logic [IDX_W-1:0] IDX_STAT = 12'h0f01;

   // First entry of each register group, most significant byte first
   localparam int E_M3A = 0;
   localparam int E_M3B = 2;
   localparam int E_M3P = 4;
   localparam int E_M2P = 8;
   localparam int E_D1A = 12;
   localparam int E_D0A = 16;
   localparam int E_D0B = 20;
   localparam int E_D0Q = 22;
   localparam int E_D0R = 26;

   localparam int CTRL_W = 7;
   localparam int UNIT_DIV0 = 0;
   localparam int UNIT_MUL2 = 2;
   localparam int UNIT_MUL3 = 3;
   localparam int STAT_BUSY_BIT = 0;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] CNT_LAST = 5'h1f;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

   typedef enum logic [2:0] {
      MODE_SMUL_SHL = 3'b000,
      MODE_SMUL = 3'b001,
      MODE_UMUL = 3'b010,
      MODE_UDIV = 3'b011,
      MODE_TRIG = 3'b100,
      MODE_ATAN = 3'b101,
      MODE_LPF = 3'b110,
      MODE_PID = 3'b111
   } mdr_mode_e;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_DIV = 1'b1
   } mdr_state_e;

   typedef struct packed {
      logic [3:0] unit;
      mdr_mode_e mode;
   } mdr_ctrl_s;

endpackage

// [hw/mdr_regs.sv]
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Functional notes
// - Multiplier 3 multiplicand: 16-bit read/write register
// - Multiplier 3 multiplier: 16-bit read/write register
// - Multiplier 3 product lands in four bytes
// - Multiplier 2 product lands in four bytes
// - Divider 0 reads 32-bit dividend register
// - Divider 0 reads 16-bit divisor register
// - Divider 0 writes quotient and remainder
// - Divider 1 dividend held in four bytes
// - Mode field picks multiply kind or division
// - One-hot unit select write starts computation
module mdr_regs (
   input wire logic REF_CLK_IN,
   input wire logic SYS_RST_IN,
   input wire logic [mdr_pkg::ADDR_W-1:0] S_AXI_AWADDR_IN,
   input wire logic S_AXI_AWVALID_IN,
   output logic S_AXI_AWREADY_OUT,
   input wire logic [mdr_pkg::DATA_W-1:0] S_AXI_WDATA_IN,
   input wire logic [mdr_pkg::DATA_W/8-1:0] S_AXI_WSTRB_IN,
   input wire logic S_AXI_WVALID_IN,
   output logic S_AXI_WREADY_OUT,
   output logic [1:0] S_AXI_BRESP_OUT,
   output logic S_AXI_BVALID_OUT,
   input wire logic S_AXI_BREADY_IN,
   input wire logic [mdr_pkg::ADDR_W-1:0] S_AXI_ARADDR_IN,
   input wire logic S_AXI_ARVALID_IN,
   output logic S_AXI_ARREADY_OUT,
   output logic [mdr_pkg::DATA_W-1:0] S_AXI_RDATA_OUT,
   output logic [1:0] S_AXI_RRESP_OUT,
   output logic S_AXI_RVALID_OUT,
   input wire logic S_AXI_RREADY_IN,
   input wire logic [2*mdr_pkg::HALF_W-1:0] MULT2_OPERANDS_IN
);
   import mdr_pkg::*;

   logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [DATA_W-1:0] rdata_ff, wdata_ff, rd_word;
   logic aw_held_ff, w_held_ff, wstrb0_ff;
   logic [ADDR_W-1:0] awaddr_ff;
   logic nxt_aw_held, nxt_w_held, nxt_rvalid;
   logic aw_fire, w_fire, ar_fire, b_done, sw_we, byte_wr;
   logic [IDX_W-1:0] wr_idx, rd_idx;
   logic wr_hit, rd_hit;

   logic [BYTE_W-1:0] regs_ff [NUM_REGS];
   logic [BYTE_W-1:0] hw_byte [NUM_REGS];
   logic [NUM_REGS-1:0] hw_we;

   mdr_ctrl_s wr_ctrl;
   mdr_mode_e mode_ff;
   mdr_state_e state_ff;
   logic ctrl_wr, is_mul, m3_go, m2_go, d0_go, div_done;
   logic [HALF_W-1:0] m3_a, m3_b, m2_a, m2_b, d0_b, d0_r;
   logic [WORD_W-1:0] m3_res, m2_res, d0_a, d0_q, m3_p, m2_p, d1_a;
   logic [CNT_W-1:0] cnt_ff;
   logic [HALF_W-1:0] rem_ff;
   logic [WORD_W-1:0] dq_ff;
   logic [HALF_W-1:0] dvs_ff;
   logic [HALF_W:0] shifted;
   logic [HALF_W+1:0] diff;
   logic [HALF_W-1:0] nxt_rem;
   logic [WORD_W-1:0] nxt_dq;

   function automatic logic mapped(input logic [IDX_W-1:0] idx);
      logic hit;
      hit = (idx == IDX_CTRL) || (idx == IDX_STAT);
      for (int e = 0; e < NUM_REGS; e++) begin
         if (idx == REG_IDX[e]) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   function automatic logic [WORD_W-1:0] mul_calc(
      input mdr_mode_e mode,
      input logic [HALF_W-1:0] a,
      input logic [HALF_W-1:0] b
   );
      logic signed [WORD_W-1:0] sp;
      sp = WORD_W'($signed(a)) * WORD_W'($signed(b));
      case (mode)
         MODE_SMUL_SHL: mul_calc = {sp[WORD_W-2:0], 1'b0};
         MODE_SMUL: mul_calc = sp;
         default: mul_calc = WORD_W'(a) * WORD_W'(b);
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel

   assign aw_fire = S_AXI_AWVALID_IN && awready_ff;
   assign w_fire = S_AXI_WVALID_IN && wready_ff;
   assign b_done = bvalid_ff && S_AXI_BREADY_IN;
   assign nxt_aw_held = aw_fire || (aw_held_ff && !b_done);
   assign nxt_w_held = w_fire || (w_held_ff && !b_done);
   assign sw_we = aw_held_ff && w_held_ff && !bvalid_ff;
   assign wr_idx = awaddr_ff[IDX_W+IDX_LSB-1:IDX_LSB];
   // Upper address bits must be clear, or the access is unmapped
   assign wr_hit = (awaddr_ff[ADDR_W-1:IDX_W+IDX_LSB] == '0) &&
                   mapped(wr_idx);
   // Registers are byte wide, so only lane 0 carries a write
   assign byte_wr = sw_we && wr_hit && wstrb0_ff;

   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
      end else begin
         aw_held_ff <= nxt_aw_held;
         w_held_ff <= nxt_w_held;
         awready_ff <= !nxt_aw_held;
         wready_ff <= !nxt_w_held;
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         awaddr_ff <= '0;
         wdata_ff <= '0;
         wstrb0_ff <= 1'b0;
      end else begin
         if (aw_fire) begin
            awaddr_ff <= S_AXI_AWADDR_IN;
         end
         if (w_fire) begin
            wdata_ff <= S_AXI_WDATA_IN;
            wstrb0_ff <= S_AXI_WSTRB_IN[0];
         end
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else if (sw_we) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (b_done) begin
         bvalid_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel

   assign ar_fire = S_AXI_ARVALID_IN && arready_ff;
   assign nxt_rvalid = ar_fire || (rvalid_ff && !S_AXI_RREADY_IN);
   assign rd_idx = S_AXI_ARADDR_IN[IDX_W+IDX_LSB-1:IDX_LSB];
   assign rd_hit = (S_AXI_ARADDR_IN[ADDR_W-1:IDX_W+IDX_LSB] == '0) &&
                   mapped(rd_idx);

   always_comb begin
      rd_word = '0;
      if (rd_hit) begin
         if (rd_idx == IDX_CTRL) begin
            rd_word[CTRL_W-1:0] = {4'h0, mode_ff};
         end
         if (rd_idx == IDX_STAT) begin
            rd_word[STAT_BUSY_BIT] = (state_ff == ST_DIV);
         end
         for (int e = 0; e < NUM_REGS; e++) begin
            if (rd_idx == REG_IDX[e]) begin
               rd_word[BYTE_W-1:0] = regs_ff[e];
            end
         end
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         rvalid_ff <= 1'b0;
         arready_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= RESP_OKAY;
      end else begin
         rvalid_ff <= nxt_rvalid;
         arready_ff <= !nxt_rvalid;
         if (ar_fire) begin
            rdata_ff <= rd_word;
            rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Operand views and control decode

   assign m3_a = {regs_ff[E_M3A], regs_ff[E_M3A+1]};
   assign m3_b = {regs_ff[E_M3B], regs_ff[E_M3B+1]};
   assign m3_p = {regs_ff[E_M3P], regs_ff[E_M3P+1],
                  regs_ff[E_M3P+2], regs_ff[E_M3P+3]};
   assign m2_p = {regs_ff[E_M2P], regs_ff[E_M2P+1],
                  regs_ff[E_M2P+2], regs_ff[E_M2P+3]};
   assign d1_a = {regs_ff[E_D1A], regs_ff[E_D1A+1],
                  regs_ff[E_D1A+2], regs_ff[E_D1A+3]};
   assign d0_a = {regs_ff[E_D0A], regs_ff[E_D0A+1],
                  regs_ff[E_D0A+2], regs_ff[E_D0A+3]};
   assign d0_b = {regs_ff[E_D0B], regs_ff[E_D0B+1]};
   assign d0_q = {regs_ff[E_D0Q], regs_ff[E_D0Q+1],
                  regs_ff[E_D0Q+2], regs_ff[E_D0Q+3]};
   assign d0_r = {regs_ff[E_D0R], regs_ff[E_D0R+1]};
   // Unit 2 operand registers live outside this block
   assign m2_a = MULT2_OPERANDS_IN[2*HALF_W-1:HALF_W];
   assign m2_b = MULT2_OPERANDS_IN[HALF_W-1:0];

   assign wr_ctrl = mdr_ctrl_s'(wdata_ff[CTRL_W-1:0]);
   assign ctrl_wr = byte_wr && (wr_idx == IDX_CTRL);
   assign is_mul = (wr_ctrl.mode == MODE_SMUL_SHL) ||
                   (wr_ctrl.mode == MODE_SMUL) ||
                   (wr_ctrl.mode == MODE_UMUL);
   // Unit bits 0, 2 and 3 each start their own unit, bit 1 starts none; modes a unit lacks are ignored
   assign m3_go = ctrl_wr && wr_ctrl.unit[UNIT_MUL3] && is_mul;
   assign m2_go = ctrl_wr && wr_ctrl.unit[UNIT_MUL2] && is_mul;
   // A start while dividing is dropped so the running result stays whole
   assign d0_go = ctrl_wr && wr_ctrl.unit[UNIT_DIV0] &&
                  (wr_ctrl.mode == MODE_UDIV) &&
                  (state_ff == ST_IDLE);
   assign m3_res = mul_calc(wr_ctrl.mode, m3_a, m3_b);
   assign m2_res = mul_calc(wr_ctrl.mode, m2_a, m2_b);

   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         mode_ff <= MODE_SMUL_SHL;
      end else if (ctrl_wr) begin
         mode_ff <= wr_ctrl.mode;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Divider 0: restoring, one quotient bit per clock

   // Divide by zero needs no special case: quotient all ones,
   // remainder ends as the low half of the dividend
   assign shifted = {rem_ff, dq_ff[WORD_W-1]};
   assign diff = {1'b0, shifted} - {2'b00, dvs_ff};
   assign nxt_rem = diff[HALF_W+1] ? shifted[HALF_W-1:0] :
                    diff[HALF_W-1:0];
   assign nxt_dq = {dq_ff[WORD_W-2:0], !diff[HALF_W+1]};
   assign div_done = (state_ff == ST_DIV) && (cnt_ff == CNT_LAST);

   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         state_ff <= ST_IDLE;
         cnt_ff <= '0;
      end else begin
         unique case (state_ff)
            ST_IDLE: begin
               cnt_ff <= '0;
               if (d0_go) begin
                  state_ff <= ST_DIV;
               end
            end
            ST_DIV: begin
               cnt_ff <= cnt_ff + 1'b1;
               if (div_done) begin
                  state_ff <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Operands are captured so later writes cannot corrupt a division
   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         rem_ff <= '0;
         dq_ff <= '0;
         dvs_ff <= '0;
      end else if (d0_go) begin
         rem_ff <= '0;
         dq_ff <= d0_a;
         dvs_ff <= d0_b;
      end else if (state_ff == ST_DIV) begin
         rem_ff <= nxt_rem;
         dq_ff <= nxt_dq;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Byte registers; a result beats a software write to the same byte

   always_comb begin
      hw_we = '0;
      for (int e = 0; e < NUM_REGS; e++) begin
         hw_byte[e] = BYTE_RST;
      end
      for (int k = 0; k < WORD_W / BYTE_W; k++) begin
         hw_byte[E_M3P+k] = m3_res[WORD_W-1-BYTE_W*k -: BYTE_W];
         hw_we[E_M3P+k] = m3_go;
         hw_byte[E_M2P+k] = m2_res[WORD_W-1-BYTE_W*k -: BYTE_W];
         hw_we[E_M2P+k] = m2_go;
         hw_byte[E_D0Q+k] = nxt_dq[WORD_W-1-BYTE_W*k -: BYTE_W];
         hw_we[E_D0Q+k] = div_done;
      end
      for (int k = 0; k < HALF_W / BYTE_W; k++) begin
         hw_byte[E_D0R+k] = nxt_rem[HALF_W-1-BYTE_W*k -: BYTE_W];
         hw_we[E_D0R+k] = div_done;
      end
   end

   for (genvar e = 0; e < NUM_REGS; e++) begin : g_reg
      always_ff @(posedge REF_CLK_IN) begin
         if (SYS_RST_IN) begin
            regs_ff[e] <= BYTE_RST;
         end else if (hw_we[e]) begin
            regs_ff[e] <= hw_byte[e];
         end else if (byte_wr && (wr_idx == REG_IDX[e])) begin
            regs_ff[e] <= wdata_ff[BYTE_W-1:0];
         end
      end
   end

   assign S_AXI_AWREADY_OUT = awready_ff;
   assign S_AXI_WREADY_OUT = wready_ff;
   assign S_AXI_BVALID_OUT = bvalid_ff;
   assign S_AXI_BRESP_OUT = bresp_ff;
   assign S_AXI_ARREADY_OUT = arready_ff;
   assign S_AXI_RVALID_OUT = rvalid_ff;
   assign S_AXI_RDATA_OUT = rdata_ff;
   assign S_AXI_RRESP_OUT = rresp_ff;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   logic [WORD_W-1:0] dvd_chk_ff;

   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         dvd_chk_ff <= '0;
      end else if (d0_go) begin
         dvd_chk_ff <= d0_a;
      end
   end

   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (SYS_RST_IN);

   sequence s_div_run;
      (state_ff == ST_DIV) [*8];
   endsequence

   sequence s_div_end;
      div_done ##1 (state_ff == ST_IDLE);
   endsequence

   wr_resp_a: assert property (sw_we |=> S_AXI_BVALID_OUT)
      else $error("write response missing");
   unmapped_rd_a: assert property (ar_fire && !rd_hit |=>
      S_AXI_RVALID_OUT && S_AXI_RRESP_OUT == RESP_SLVERR)
      else $error("unmapped read not refused");
   m3_multiplicand_a: assert property (
      byte_wr && wr_idx == REG_IDX[E_M3A] |=>
      regs_ff[E_M3A] == $past(wdata_ff[BYTE_W-1:0]))
      else $error("multiplicand byte not stored");
   m3_multiplier_a: assert property (
      byte_wr && wr_idx == REG_IDX[E_M3B+1] |=>
      m3_b[BYTE_W-1:0] == $past(wdata_ff[BYTE_W-1:0]))
      else $error("multiplier byte not stored");
   m3_product_a: assert property (
      m3_go && wr_ctrl.mode == MODE_UMUL |=>
      m3_p == WORD_W'($past(m3_a)) * WORD_W'($past(m3_b)))
      else $error("unit 3 unsigned product wrong");
   shl_product_a: assert property (
      m3_go && wr_ctrl.mode == MODE_SMUL_SHL |=> m3_p ==
      WORD_W'($signed($past(m3_a))) * WORD_W'($signed($past(m3_b))) * 2)
      else $error("shifted signed product wrong");
   m2_product_a: assert property (
      m2_go && wr_ctrl.mode == MODE_SMUL |=> m2_p ==
      WORD_W'($signed($past(m2_a))) * WORD_W'($signed($past(m2_b))))
      else $error("unit 2 signed product wrong");
   div_timing_a: assert property (
      d0_go |=> s_div_run ##24 s_div_end)
      else $error("division did not take 32 steps");
   divisor_cap_a: assert property (
      d0_go |=> dvs_ff == $past(d0_b))
      else $error("divisor not captured at start");
   div_result_a: assert property (
      div_done && dvs_ff != '0 |=> d0_r < dvs_ff &&
      48'(d0_q) * 48'(dvs_ff) + 48'(d0_r) == 48'(dvd_chk_ff))
      else $error("quotient or remainder wrong");
   d1_dividend_a: assert property (
      byte_wr && wr_idx == REG_IDX[E_D1A] |=>
      d1_a[WORD_W-1 -: BYTE_W] == $past(wdata_ff[BYTE_W-1:0]))
      else $error("divider 1 dividend byte not stored");

endmodule

// [sim/mul_div_operand_result_regs_bench.sv]
`timescale 1ns/1ps
module mul_div_operand_result_regs_bench;
   import mdr_pkg::*;

   localparam int LIMIT = 200;

   logic clk;
   logic rst;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp, resp;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata, v, da, exp_q;
   logic [3:0] wstrb;
   logic [31:0] mult2_ops;
   logic [15:0] a, b, db;
   logic [2:0] md;
   logic [7:0] bytes_exp [NUM_REGS];
   int error_cnt, n_compared, i, m, n;

   mdr_regs DUT (
      .REF_CLK_IN(clk), .SYS_RST_IN(rst),
      .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
      .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
      .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
      .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
      .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
      .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
      .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
      .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
      .S_AXI_RREADY_IN(rready), .MULT2_OPERANDS_IN(mult2_ops)
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic fail_timeout();
      error_cnt++;
      $display("[FAIL] %0t wait ran out, got %h expected %h", $time, 0, 1);
      end_sim();
   endtask

   task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t data got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t resp got %h expected %h", $time, got, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Sample at the falling edge; registered outputs hold until the next
   // rising edge, so this is what the handshake edge sees.
   task automatic axi_write(input logic [IDX_W-1:0] idx, input logic [7:0] d,
                            output logic [1:0] r);
      logic ta, tw, got;
      int k;
      awaddr <= ADDR_W'({idx, 2'b00});
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      k = 0;
      do begin
         @(negedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         got = bready && bvalid;
         if (got) r = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (++k > LIMIT) fail_timeout();
      end while (!got);
      bready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic axi_read(input logic [IDX_W-1:0] idx,
                           output logic [31:0] d, output logic [1:0] r);
      logic ta, got;
      int k;
      araddr <= ADDR_W'({idx, 2'b00});
      arvalid <= 1'b1;
      rready <= 1'b1;
      k = 0;
      do begin
         @(negedge clk);
         ta = arvalid && arready;
         got = rready && rvalid;
         if (got) d = rdata;
         if (got) r = rresp;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
         if (++k > LIMIT) fail_timeout();
      end while (!got);
      rready <= 1'b0;
      @(posedge clk);
   endtask

   // Multi-byte values: lowest entry carries the most significant byte
   task automatic write_val(input int e, input int nb, input logic [31:0] val);
      logic [31:0] t;
      logic [1:0] r;
      for (int k = 0; k < nb; k++) begin
         t = val >> (8 * (nb - 1 - k));
         axi_write(REG_IDX[e+k], t[7:0], r);
         cmp_resp(r, RESP_OKAY);
      end
   endtask

   task automatic read_val(input int e, input int nb, output logic [31:0] val);
      logic [31:0] d;
      logic [1:0] r;
      val = 32'h0000_0000;
      for (int k = 0; k < nb; k++) begin
         axi_read(REG_IDX[e+k], d, r);
         cmp_resp(r, RESP_OKAY);
         val = {val[23:0], d[7:0]};
      end
   endtask

   function automatic logic [31:0] exp_mul(input logic [2:0] mode,
                                           input logic [15:0] x,
                                           input logic [15:0] y);
      logic signed [31:0] p;
      p = $signed(x) * $signed(y);
      if (mode == 3'b000) return p << 1;
      if (mode == 3'b001) return p;
      return {16'h0000, x} * {16'h0000, y};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   initial begin
      error_cnt = 0;
      n_compared = 0;
      rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'h1;
      mult2_ops = 32'h0000_0000;
      void'($urandom(32'ha6e1));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (i = 0; i < NUM_REGS; i++) begin
         read_val(i, 1, v);
         cmp_data(v, 32'h0000_0000);
      end
      for (i = 0; i < NUM_REGS; i++) begin
         bytes_exp[i] = 8'($urandom());
         write_val(i, 1, {24'h00_0000, bytes_exp[i]});
      end
      for (i = 0; i < NUM_REGS; i++) begin
         read_val(i, 1, v);
         cmp_data(v, {24'h00_0000, bytes_exp[i]});
      end
      // Strobe off: accepted but stores nothing
      wstrb <= 4'h0;
      axi_write(REG_IDX[E_D1A], ~bytes_exp[E_D1A], resp);
      cmp_resp(resp, RESP_OKAY);
      wstrb <= 4'h1;
      read_val(E_D1A, 1, v);
      cmp_data(v, {24'h00_0000, bytes_exp[E_D1A]});
      // Neighbouring unit's operand lies outside this block
      axi_write(12'h0f40, 8'h5a, resp);
      cmp_resp(resp, RESP_SLVERR);
      axi_read(12'h0f40, v, resp);
      cmp_resp(resp, RESP_SLVERR);
      cmp_data(v, 32'h0000_0000);
      for (m = 0; m < 3; m++) begin
         md = 3'(m);
         for (i = 0; i < 5; i++) begin
            a = (i == 0) ? 16'h8000 : (i == 1) ? 16'hffff : 16'($urandom());
            b = (i == 0) ? 16'h8000 : (i == 1) ? 16'h7fff : 16'($urandom());
            write_val(E_M3A, 2, {16'h0000, a});
            write_val(E_M3B, 2, {16'h0000, b});
            axi_write(IDX_CTRL, {1'b0, 4'b1000, md}, resp);
            read_val(E_M3P, 4, v);
            cmp_data(v, exp_mul(md, a, b));
         end
         axi_read(IDX_CTRL, v, resp);
         cmp_data(v, {29'h0000_0000, md});
      end
      // Division mode on a multiplier unit computes nothing
      exp_q = exp_mul(3'b010, a, b);
      axi_write(IDX_CTRL, {1'b0, 4'b1000, 3'b011}, resp);
      read_val(E_M3P, 4, v);
      cmp_data(v, exp_q);
      for (i = 0; i < 4; i++) begin
         mult2_ops <= $urandom();
         // Every multiply mode is visited; operands stay random
         md = 3'(i % 3);
         axi_write(IDX_CTRL, {1'b0, 4'b0100, md}, resp);
         read_val(E_M2P, 4, v);
         cmp_data(v, exp_mul(md, mult2_ops[31:16],
                             mult2_ops[15:0]));
      end
      for (i = 0; i < 5; i++) begin
         da = (i == 0) ? 32'hffff_ffff : $urandom();
         db = (i == 1) ? 16'h0000 : (i == 2) ? 16'hffff : 16'($urandom());
         write_val(E_D0A, 4, da);
         write_val(E_D0B, 2, {16'h0000, db});
         axi_write(IDX_CTRL, {1'b0, 4'b0001, 3'b011}, resp);
         axi_read(IDX_STAT, v, resp);
         cmp_data(v & 32'h0000_0001, 32'h0000_0001);
         n = 0;
         while (v[STAT_BUSY_BIT] === 1'b1) begin
            axi_read(IDX_STAT, v, resp);
            if (++n > LIMIT) fail_timeout();
         end
         exp_q = (db == 16'h0000) ? 32'hffff_ffff : da / {16'h0000, db};
         read_val(E_D0Q, 4, v);
         cmp_data(v, exp_q);
         exp_q = (db == 16'h0000) ? {16'h0000, da[15:0]}
                                  : da % {16'h0000, db};
         read_val(E_D0R, 2, v);
         cmp_data(v, exp_q);
      end
      end_sim();
   end
endmodule
